// >>> logic/adcc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the converter control.
// Assumes: 100 MHz core clock, APB register access.
// Notes:   definitions only.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Timing
`define ADCC_CORE_HZ        100000000
`define ADCC_OSC_HZ         1000000
`define ADCC_OSC_DIV        (`ADCC_CORE_HZ / `ADCC_OSC_HZ)
`define ADCC_MOD_DIV        4
`define ADCC_OSR_LOG2       15

// Register offsets
`define ADCC_OFF_CONFIG     8'h00
`define ADCC_OFF_RESULT     8'h04
`define ADCC_OFF_STATUS     8'h08
`define ADCC_OFF_BYTE       8'h0c
`define ADCC_OFF_LSB_PV     8'h10

// Configuration fields
`define ADCC_CFG_ONESHOT    0
`define ADCC_CFG_GAIN_LO    1
`define ADCC_CFG_GAIN_HI    3
`define ADCC_CFG_MODE       4
`define ADCC_CFG_TEMP       5

// Status fields
`define ADCC_STA_BUSY       0
`define ADCC_STA_NEW        1
`define ADCC_STA_BYTEPTR    2

// Reset values
`define ADCC_RST_GAIN       3'h2
`define ADCC_RST_MODE       1'b1
`define ADCC_RST_TEMP       1'b0

// Gain codes
`define ADCC_GAIN_6144      3'h0
`define ADCC_GAIN_4096      3'h1
`define ADCC_GAIN_2048      3'h2
`define ADCC_GAIN_1024      3'h3
`define ADCC_GAIN_0512      3'h4

// Code step weight in picovolts
`define ADCC_LSB_6144       32'h0b2d_05e0
`define ADCC_LSB_4096       32'h0773_5940
`define ADCC_LSB_2048       32'h03b9_aca0
`define ADCC_LSB_1024       32'h01dc_d650
`define ADCC_LSB_0512       32'h00ee_6b28
`define ADCC_LSB_0256       32'h0077_3594

// Result codes
`define ADCC_POS_FULL       16'h7fff
`define ADCC_NEG_FULL       16'h8000

`endif

// >>> logic/adcc_pkg.sv
// Purpose: types shared by the converter control modules.
// Assumes: nothing beyond SystemVerilog.
// Notes:   state machine codes are one-hot.
package adcc_pkg;

	typedef enum logic [1:0] {
		ADCC_ST_DOWN = 2'b01,
		ADCC_ST_CONV = 2'b10
	} adcc_state_t;

	typedef struct packed {
		logic [15:0]        cnt;
		logic signed [16:0] sum;
		logic               done;
		logic [15:0]        result;
	} adcc_dec_t;

	typedef struct packed {
		adcc_state_t state;
		logic [6:0]  osc_cnt;
		logic        osc_tick;
		logic [1:0]  mod_cnt;
		logic        mod_tick;
		logic [2:0]  gain_range_select;
		logic        temp_sense_select;
		logic        mode;
		logic        one_shot;
		logic        dec_clear;
		logic [15:0] result;
		logic        data_new;
		logic        byte_ptr;
		logic [7:0]  lsb_hold;
		logic [31:0] prdata;
		logic        pslverr;
		logic [1:0]  mbit_sync;
		logic [1:0]  tbit_sync;
	} adcc_core_t;

endpackage

// >>> logic/adcc_decimator.sv
// Purpose: counts a one-bit modulator stream over a fixed window into a 16-bit code.
// Assumes: sample_en is a one-cycle enable at the modulator rate.
// Notes:   window is 2^OSR_LOG2 samples; the sum is scaled up to 16 bits.
`include "adcc_defines.svh"

module adcc_decimator #(
	parameter int OSR_LOG2 = `ADCC_OSR_LOG2
) (
	input  wire logic        core_clk,  // Core clock
	input  wire logic        reset_n,   // Asynchronous reset
	input  wire logic        clear,     // Restart the window
	input  wire logic        sample_en, // One modulator sample
	input  wire logic        bit_in,    // Modulator bit
	output logic             done,      // Window finished
	output logic [15:0]      result     // Saturated two's complement code
);
	import adcc_pkg::*;

	localparam logic [15:0] LAST = 16'((32'd1 << OSR_LOG2) - 32'd1);

	adcc_dec_t s;
	adcc_dec_t n;

	////////////////////////////////////////////////////////////////////////////
	// Scale to full 16-bit span and clip
	function automatic logic [15:0] clip(input logic signed [16:0] sum);
		logic signed [31:0] scaled;
		scaled = 32'(sum) <<< (15 - OSR_LOG2);
		if (scaled > 32'sd32767)
			clip = `ADCC_POS_FULL;
		else if (scaled < -32'sd32768)
			clip = `ADCC_NEG_FULL;
		else
			clip = scaled[15:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic signed [16:0] next_sum;
		next_sum = s.sum + (bit_in ? 17'sd1 : -17'sd1);
		n = s;
		n.done = 1'b0;
		if (clear) begin
			n.cnt = 16'h0000;
			n.sum = 17'sh00000;
		end else if (sample_en) begin
			if (s.cnt == LAST) begin
				n.result = clip(next_sum);
				n.done = 1'b1;
				n.cnt = 16'h0000;
				n.sum = 17'sh00000;
			end else begin
				n.sum = next_sum;
				n.cnt = s.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			s <= '0;
		else
			s <= n;
	end

	assign done = s.done;
	assign result = s.result;

endmodule

// >>> logic/adcc_core.sv
// Purpose: control of a delta-sigma converter: oscillator and modulator rate, gain,
//          temperature sensing, single-shot and continuous modes, APB registers.
// Assumes: modulator and sensor bit streams arrive from analog logic outside this clock.
// Notes:   the 1 MHz oscillator and 250 kHz modulator rate are enables of core_clk.
`include "adcc_defines.svh"

module adcc_core #(
	parameter int OSR_LOG2 = `ADCC_OSR_LOG2
) (
	input  wire logic        core_clk,          // Core clock, 100 MHz
	input  wire logic        reset_n,           // Power-up reset, active low
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB access phase
	input  wire logic        pwrite,            // APB write
	input  wire logic [7:0]  paddr,             // APB byte address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic [31:0]      prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error, unmapped address
	input  wire logic        mod_bit_in,        // Input modulator bit stream
	input  wire logic        temp_bit_in,       // Temperature sensor bit stream
	output logic             modulator_clock,   // 250 kHz modulator clock
	output logic             converter_power,   // Analog converter powered up
	output logic [2:0]       gain_range_select, // Gain range to the amplifier
	output logic             temp_sense_select  // Sensor routed to the modulator
);
	import adcc_pkg::*;

	adcc_core_t  s;
	adcc_core_t  n;
	logic        dec_done;
	logic [15:0] dec_result;
	logic        dec_bit;
	logic        sample_en;

	////////////////////////////////////////////////////////////////////////////
	// Code step weight of the selected range
	function automatic logic [31:0] lsb_weight(input logic [2:0] gain);
		case (gain)
			`ADCC_GAIN_6144: lsb_weight = `ADCC_LSB_6144;
			`ADCC_GAIN_4096: lsb_weight = `ADCC_LSB_4096;
			`ADCC_GAIN_2048: lsb_weight = `ADCC_LSB_2048;
			`ADCC_GAIN_1024: lsb_weight = `ADCC_LSB_1024;
			`ADCC_GAIN_0512: lsb_weight = `ADCC_LSB_0512;
			default:         lsb_weight = `ADCC_LSB_0256; // Codes 5 to 7 share the narrowest
		endcase
	endfunction

	// Register offset decode, done in the setup phase and registered for the access phase
	function automatic logic mapped(input logic [7:0] addr);
		case (addr)
			`ADCC_OFF_CONFIG, `ADCC_OFF_RESULT, `ADCC_OFF_STATUS,
			`ADCC_OFF_BYTE, `ADCC_OFF_LSB_PV: mapped = 1'b1;
			default:                           mapped = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Decimation filter
	// Machinery only sees enables while converting, so it idles when powered down.
	assign sample_en = s.mod_tick && (s.state == ADCC_ST_CONV);
	assign dec_bit = s.temp_sense_select ? s.tbit_sync[1] : s.mbit_sync[1];

	adcc_decimator #(
		.OSR_LOG2  (OSR_LOG2)
	) u_dec (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.clear     (s.dec_clear),
		.sample_en (sample_en),
		.bit_in    (dec_bit),
		.done      (dec_done),
		.result    (dec_result)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic access;
		logic setup;
		logic start;
		access = psel && penable;
		setup = psel && !penable;
		start = 1'b0;
		n = s;
		n.dec_clear = 1'b0;

		// Bit stream synchronisers
		n.mbit_sync = {s.mbit_sync[0], mod_bit_in};
		n.tbit_sync = {s.tbit_sync[0], temp_bit_in};

		// Internal oscillator from the core clock; no external clock is used
		n.osc_tick = 1'b0;
		if (s.osc_cnt == 7'(`ADCC_OSC_DIV - 1)) begin
			n.osc_cnt = 7'h00;
			n.osc_tick = 1'b1;
		end else begin
			n.osc_cnt = s.osc_cnt + 7'h01;
		end

		// Modulator rate follows the oscillator, so data rate scales with it
		n.mod_tick = 1'b0;
		if (s.osc_tick) begin
			n.mod_cnt = s.mod_cnt + 2'h1;
			if (s.mod_cnt == 2'(`ADCC_MOD_DIV - 1))
				n.mod_tick = 1'b1;
		end

		// Register setup phase: read data prepared ahead of the access phase
		if (setup) begin
			n.pslverr = !mapped(paddr);
			n.prdata = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					`ADCC_OFF_CONFIG: begin
						n.prdata[`ADCC_CFG_ONESHOT] = s.one_shot;
						n.prdata[`ADCC_CFG_GAIN_HI:`ADCC_CFG_GAIN_LO] = s.gain_range_select;
						n.prdata[`ADCC_CFG_MODE] = s.mode;
						n.prdata[`ADCC_CFG_TEMP] = s.temp_sense_select;
					end
					`ADCC_OFF_RESULT: n.prdata[15:0] = s.result;
					`ADCC_OFF_STATUS: begin
						n.prdata[`ADCC_STA_BUSY] = (s.state == ADCC_ST_CONV);
						n.prdata[`ADCC_STA_NEW] = s.data_new;
						n.prdata[`ADCC_STA_BYTEPTR] = s.byte_ptr;
					end
					`ADCC_OFF_BYTE: begin
						if (s.byte_ptr)
							n.prdata[7:0] = s.lsb_hold;
						else
							n.prdata[7:0] = s.result[15:8];
					end
					`ADCC_OFF_LSB_PV: n.prdata = lsb_weight(s.gain_range_select);
					default:          n.prdata = 32'h0000_0000;
				endcase
			end
		end

		// Register access phase: writes and read side effects
		if (access && !s.pslverr) begin
			if (pwrite) begin
				if (paddr == `ADCC_OFF_CONFIG) begin
					n.gain_range_select =
						pwdata[`ADCC_CFG_GAIN_HI:`ADCC_CFG_GAIN_LO];
					n.mode = pwdata[`ADCC_CFG_MODE];
					n.temp_sense_select = pwdata[`ADCC_CFG_TEMP];
					// A trigger while converting is dropped
					if (pwdata[`ADCC_CFG_ONESHOT] && s.state == ADCC_ST_DOWN)
						n.one_shot = 1'b1;
				end
			end else begin
				if (paddr == `ADCC_OFF_RESULT)
					n.data_new = 1'b0;
				if (paddr == `ADCC_OFF_BYTE) begin
					// Low byte is locked when the high byte goes out
					if (!s.byte_ptr) begin
						n.lsb_hold = s.result[7:0];
						n.byte_ptr = 1'b1;
					end else begin
						n.byte_ptr = 1'b0;
						n.data_new = 1'b0;
					end
				end
			end
		end

		// Conversion sequencing
		case (s.state)
			ADCC_ST_DOWN: begin
				if (!s.mode) begin
					start = 1'b1;
				end else if (s.one_shot) begin
					start = 1'b1;
					n.one_shot = 1'b0;
				end
				if (start) begin
					n.state = ADCC_ST_CONV;
					n.dec_clear = 1'b1;
					n.mod_cnt = 2'h0;
				end
			end
			ADCC_ST_CONV: begin
				if (dec_done) begin
					// Sensor word is 14 bits at the top, low bits forced clear
					if (s.temp_sense_select)
						n.result = {dec_result[15:2], 2'b00};
					else
						n.result = dec_result;
					// New data wins over a clearing read in the same cycle
					n.data_new = 1'b1;
					// Continuous mode keeps the window running without a gap
					if (s.mode)
						n.state = ADCC_ST_DOWN;
					else
						n.state = ADCC_ST_CONV;
				end
			end
			default: n.state = ADCC_ST_DOWN;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-up reset loads defaults and leaves the converter down
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.state <= ADCC_ST_DOWN;
			s.gain_range_select <= `ADCC_RST_GAIN;
			s.mode <= `ADCC_RST_MODE;
			s.temp_sense_select <= `ADCC_RST_TEMP;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = s.pslverr && psel && penable;
	assign modulator_clock = s.mod_cnt[1] && (s.state == ADCC_ST_CONV);
	assign converter_power = (s.state == ADCC_ST_CONV);
	assign gain_range_select = s.gain_range_select;
	assign temp_sense_select = s.temp_sense_select;

endmodule

// >>> tb/adcc_core_monitor.sv
// Purpose: port-level assertions for the converter control.
// Assumes: 100 MHz core_clk, asynchronous active-low reset_n.
// Notes:   bound to adcc_core.
////////////////////////////////////////////////////////////////
module adcc_core_chk #(
	parameter int OSR_LOG2 = 15
) (
	input wire logic        core_clk,          // Clock
	input wire logic        reset_n,           // Reset
	input wire logic        psel,              // APB select
	input wire logic        penable,           // APB enable
	input wire logic        pwrite,            // APB write
	input wire logic [7:0]  paddr,             // APB address
	input wire logic [31:0] pwdata,            // APB write data
	input wire logic [31:0] prdata,            // APB read data
	input wire logic        pready,            // APB ready
	input wire logic        pslverr,           // APB error
	input wire logic        mod_bit_in,        // Input stream
	input wire logic        temp_bit_in,       // Sensor stream
	input wire logic        modulator_clock,   // Modulator clock
	input wire logic        converter_power,   // Converter on
	input wire logic [2:0]  gain_range_select, // Gain range
	input wire logic        temp_sense_select  // Sensor select
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic       cfg_wr;
	logic [2:0] wr_gain;
	logic       wr_temp;
	logic [7:0] hi_cnt;
	logic [8:0] per_cnt;
	logic       seen;
	logic       mode_q;
	assign cfg_wr  = psel && penable && pwrite && paddr == 8'h00;
	assign wr_gain = pwdata[3:1];
	assign wr_temp = pwdata[5];
	// Period is timed only from the second rise of a session, the first may be short
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_cnt  <= 8'h0;
			per_cnt <= 9'h0;
			seen    <= 1'b0;
			mode_q  <= 1'b1;
		end else begin
			hi_cnt  <= modulator_clock ? hi_cnt + 8'h1 : 8'h0;
			per_cnt <= $rose(modulator_clock) ? 9'h1 : per_cnt + 9'h1;
			seen    <= converter_power && (seen || $rose(modulator_clock));
			if (cfg_wr)
				mode_q <= pwdata[4];
		end
	end
	mod_idle_a: assert property (!converter_power |-> !modulator_clock)
		else $error("modulator clock runs while powered down");
	mod_period_a: assert property ($rose(modulator_clock) && seen |-> per_cnt == 9'h190)
		else $error("modulator period is not 400 cycles");
	// Power only drops with the clock already low, so every high phase is full length
	mod_high_a: assert property ($fell(modulator_clock) |-> hi_cnt == 8'hc8)
		else $error("modulator high phase not 200 cycles");
	gain_set_a: assert property (cfg_wr |=> gain_range_select == $past(wr_gain))
		else $error("gain range not taken from write");
	temp_set_a: assert property (cfg_wr |=> temp_sense_select == $past(wr_temp))
		else $error("sensor select not taken from write");
	// The trigger is stored by the write and taken one cycle later
	shot_start_a: assert property (cfg_wr && pwdata[0] && pwdata[4] && !converter_power
		|-> ##2 converter_power)
		else $error("single shot did not start");
	idle_hold_a: assert property (!converter_power && !cfg_wr && !$past(cfg_wr)
		|=> !converter_power)
		else $error("converter woke without a command");
	cont_hold_a: assert property (converter_power && !mode_q |=> converter_power)
		else $error("continuous mode stopped");
	temp_low_a: assert property (psel && penable && !pwrite && paddr == 8'h04 &&
		temp_sense_select |-> prdata[1:0] == 2'h0)
		else $error("sensor result low bits not zero");
	cover property (cfg_wr && pwdata[0] && !converter_power);
	cover property (converter_power && !mode_q ##1 converter_power);
	cover property (psel && penable && paddr == 8'h04 && temp_sense_select);
endmodule

bind adcc_core adcc_core_chk #(.OSR_LOG2(OSR_LOG2)) u_chk (.core_clk(core_clk),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mod_bit_in(mod_bit_in), .temp_bit_in(temp_bit_in), .modulator_clock(modulator_clock),
	.converter_power(converter_power), .gain_range_select(gain_range_select),
	.temp_sense_select(temp_sense_select));

// >>> tb/adcc_front_model.sv
// Purpose: analog front end giving the modulator and sensor bit streams.
// Assumes: streams are held at a level chosen by the bench while powered.
// Notes:   behavioural only.
////////////////////////////////////////////////////////////////
module adcc_front_model (
	input wire logic core_clk,        // Clock
	input wire logic converter_power, // Converter on
	input wire logic lvl_mod,         // Input stream level
	input wire logic lvl_temp,        // Sensor stream level
	output logic     mod_bit_in,      // Input stream
	output logic     temp_bit_in      // Sensor stream
);
	initial begin
		mod_bit_in = 1'b0;
		temp_bit_in = 1'b1;
	end
	// Unpowered streams toggle, so stale data never looks valid
	always @(posedge core_clk) begin
		mod_bit_in <= converter_power ? lvl_mod : ~mod_bit_in;
		temp_bit_in <= converter_power ? lvl_temp : ~temp_bit_in;
	end
endmodule

// >>> tb/adcc_core_tb_top.sv
// Purpose: self-checking bench for the converter control.
// Assumes: APB master here, front end model on the streams.
// Notes:   short conversion window via OSR_LOG2.
////////////////////////////////////////////////////////////////
module adcc_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready;
	logic        pslverr;
	logic        rerr;
	logic        mod_bit_in;
	logic        temp_bit_in;
	logic        modulator_clock;
	logic        converter_power;
	logic        temp_sense_select;
	logic [2:0]  gain_range_select;
	logic        lvl_mod = 1'b0;
	logic        lvl_temp = 1'b0;
	int          n_fail = 0;
	int          num_checks = 0;

	adcc_core #(.OSR_LOG2(3)) DUT (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mod_bit_in(mod_bit_in),
		.temp_bit_in(temp_bit_in), .modulator_clock(modulator_clock),
		.converter_power(converter_power), .gain_range_select(gain_range_select),
		.temp_sense_select(temp_sense_select));
	adcc_front_model u_front (.core_clk(core_clk), .converter_power(converter_power),
		.lvl_mod(lvl_mod), .lvl_temp(lvl_temp), .mod_bit_in(mod_bit_in),
		.temp_bit_in(temp_bit_in));

	always #5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			n_fail++;
			$display("ERROR %0t: bus transfer not answered", $time);
			stop_test();
		end
	endtask
	task automatic wait_pwr(input logic lv);
		for (int i = 0; i < 8000 && converter_power !== lv; i++)
			@(negedge core_clk);
		if (converter_power !== lv) begin
			n_fail++;
			$display("ERROR %0t: converter power did not change", $time);
			stop_test();
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		apb(1'b0, 8'h00, 32'h0);
		chk(rdat, 32'h14);
		chk(32'(gain_range_select), 32'h2);
		chk(32'(converter_power), 32'h0);
		apb(1'b1, 8'h14, 32'h3f);
		chk(32'(rerr), 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdat, 32'h14);
		$display("reset test done");
	endtask
	task automatic t_gain;
		logic [31:0] lsb[8] = '{32'h0b2d05e0, 32'h07735940, 32'h03b9aca0, 32'h01dcd650,
			32'h00ee6b28, 32'h00773594, 32'h00773594, 32'h00773594};
		for (int g = 0; g < 8; g++) begin
			apb(1'b1, 8'h00, 32'h10 | 32'(g << 1));
			apb(1'b0, 8'h10, 32'h0);
			chk(rdat, lsb[g]);
			chk(32'(gain_range_select), 32'(g));
		end
		$display("gain test done");
	endtask
	task automatic t_single;
		lvl_mod <= 1'b1;
		lvl_temp <= 1'b0;
		apb(1'b1, 8'h00, 32'h11);
		wait_pwr(1'b1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdat, 32'h10);
		apb(1'b1, 8'h00, 32'h11);
		wait_pwr(1'b0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat, 32'h7fff);
		apb(1'b0, 8'h00, 32'h0);
		chk(rdat, 32'h10);
		$display("single shot test done");
	endtask
	task automatic t_temp;
		lvl_mod <= 1'b0;
		lvl_temp <= 1'b1;
		apb(1'b1, 8'h00, 32'h31);
		wait_pwr(1'b1);
		chk(32'(temp_sense_select), 32'h1);
		wait_pwr(1'b0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat, 32'h7ffc);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rdat, 32'h7f);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rdat, 32'hfc);
		lvl_temp <= 1'b0;
		apb(1'b1, 8'h00, 32'h31);
		wait_pwr(1'b1);
		wait_pwr(1'b0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdat, 32'h8000);
		$display("sensor test done");
	endtask
	task automatic t_cont;
		lvl_mod <= 1'b1;
		apb(1'b1, 8'h00, 32'h00);
		wait_pwr(1'b1);
		for (int i = 0; i < 2000 && rdat !== 32'h7fff; i++)
			apb(1'b0, 8'h04, 32'h0);
		chk(rdat, 32'h7fff);
		chk(32'(converter_power), 32'h1);
		apb(1'b1, 8'h00, 32'h10);
		wait_pwr(1'b0);
		$display("continuous test done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_gain();
		t_single();
		t_temp();
		t_cont();
		stop_test();
	end
endmodule
